/* File: hdl/htt_dev_end.sv */
// switch end of the host-port trailer logic
// Contract
// (RULE1) trailer byte sits right before the fcs
// (RULE2) frames to host get one ingress-port trailer
// (RULE3) bits 1:0 give ingress port, 6:2 reserved
// (RULE4) bit 7 set only when timestamp precedes
// (RULE5) host reads bit 7 to find timestamp
// (RULE6) host appends one trailer to every frame
// (RULE7) switch strips host trailer before egress
// (RULE8) lookup bit 6 makes bits 5:0 ignored
// (RULE9) bits 2:0 select ports 3, 2, 1
// (RULE10) bits 4:3 select egress priority queue
// (RULE11) bit 5 overrides spanning tree blocking
// (RULE12) trailers only on the single host port
// (RULE13) tagging off after reset; enable picks host
// (RULE14) software enables trailer on one port only
// (RULE15) precision-time mode adds 4-byte timestamp
// (RULE16) timestamp: 2 bits seconds, 30 nanoseconds
// (RULE17) host sends timestamp field in every frame
// (RULE18) host copies delay timestamp, else zeros
// (RULE19) igmp over ipv4 trapped to host only
// (RULE20) mld frames trapped to host only
// (RULE21) blocked ports send no normal frames
// (RULE22) fcs recomputed after insert or strip
`default_nettype none
module htt_dev_end
   import htt_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // link to the host mac
   htt_link_if.dev_end lnk,
   // configuration
   input wire logic [2:0] trailer_enable,
   input wire logic [1:0] link_port,
   input wire logic [7:0] precision_time_cfg1,
   input wire logic [2:0] port_tx_enable,
   // frames bound for the host
   input wire logic [7:0] ing_data,
   input wire logic ing_valid,
   input wire logic ing_last,
   output logic ing_ready,
   input wire logic [1:0] ing_port,
   input wire logic ing_ptp,
   input wire logic [1:0] ing_ts_sec,
   input wire logic [29:0] ing_ts_ns,
   input wire logic [2:0] ing_lookup_mask,
   output logic ing_trap,
   output logic [2:0] ing_fwd_mask,
   // frames from the host
   input wire logic [2:0] egr_lookup_mask,
   output logic [7:0] egr_data,
   output logic egr_valid,
   output logic egr_last,
   output logic [2:0] egr_mask,
   output logic [1:0] egr_prio,
   output logic egr_lookup,
   output logic egr_override,
   output logic [31:0] egr_ts,
   output logic egr_fcs_err
);
   localparam logic [3:0] DEV_DEPTH = TAIL_TS;

   typedef struct packed {
      logic tag_on;
      logic ptp_on;
      logic [2:0] host_mask;
      htt_tx_type tx;
      logic [POS_W-1:0] pos;
      logic [POS_W-1:0] tpos;
      logic [POS_W-1:0] ip_base;
      logic [7:0] prev;
      logic [7:0] nh;
      logic v4;
      logic v6;
      logic snap;
      logic hop;
      logic trap;
      logic ing_trap;
      logic [2:0] ing_fwd_mask;
      htt_rx_type rx;
      logic [2:0] egr_mask;
      logic [1:0] egr_prio;
      logic egr_lookup;
      logic egr_override;
      logic [31:0] egr_ts;
      logic egr_fcs_err;
   } htt_dev_state_type;

   htt_dev_state_type r;
   htt_dev_state_type next_r;

   assign ing_ready = r.tx.st == TX_DATA;

   always_comb begin
      logic take;
      logic ts_flag;
      logic lookup;
      logic [7:0] tag;
      logic [15:0] etype;
      logic [POS_W-1:0] rel;
      logic [3:0] strip;
      take = ing_valid && ing_ready;
      lookup = 1'b0;
      etype = {r.prev, ing_data};
      rel = r.pos - r.ip_base;
      next_r = r;
      // a lone enable matching the link port makes it the host port
      next_r.tag_on = trailer_enable == (ONE_PORT << link_port); // see (RULE12) (RULE14)
      next_r.host_mask = ONE_PORT << link_port;
      next_r.ptp_on = precision_time_cfg1[PTP_MODE_BIT];

      // switch to host: payload, [timestamp], trailer, new fcs
      ts_flag = r.tag_on && r.ptp_on && ing_ptp; // see (RULE4) (RULE15)
      tag = {ts_flag, RESERVED_ZERO, ing_port}; // see (RULE2) (RULE3)
      next_r.tx = htt_tx_step(r.tx, take, ing_data, ing_last,
         ts_flag ? {htt_ts_pack(ing_ts_sec, ing_ts_ns), tag} // see (RULE16)
                 : {tag, TS_ZERO},
         !r.tag_on ? NO_TAIL : (ts_flag ? TS_TAG_LEN : TAG_LEN)); // see (RULE1)

      // trap classifier on the same byte stream
      if (take) begin
         next_r.pos = r.pos + POS_ONE;
         next_r.prev = ing_data;
         if (r.pos == r.tpos) begin
            if (etype == ET_VLAN) begin
               next_r.tpos = r.tpos + VLAN_LEN;
            end else if (etype == ET_IPV4) begin
               next_r.v4 = 1'b1;
               next_r.ip_base = r.pos + POS_ONE;
            end else if (etype == ET_IPV6) begin
               next_r.v6 = 1'b1;
               next_r.ip_base = r.pos + POS_ONE;
            end else if (etype < ET_MAX_LEN) begin
               next_r.snap = 1'b1;
               next_r.ip_base = r.pos + POS_ONE + SNAP_LEN;
            end
         end
         if (r.snap && r.pos == r.ip_base - POS_ONE && etype == ET_IPV4) begin
            next_r.v4 = 1'b1;
         end
         if (r.v4 && rel == V4_VER_OFF && ing_data[7:4] != IPV4_VER) begin
            next_r.v4 = 1'b0;
         end
         if (r.v4 && rel == V4_PROTO_OFF && ing_data == IGMP_PROTO) begin
            next_r.trap = 1'b1; // see (RULE19)
         end
         if (r.v6 && rel == V6_NH_OFF) begin
            next_r.nh = ing_data;
         end
         if (r.v6 && rel == V6_HDR_LEN) begin
            if (r.nh == NH_ICMPV6 && htt_is_mld(ing_data)) begin
               next_r.trap = 1'b1; // see (RULE20)
            end
            if (r.nh == NH_HOP) begin
               next_r.hop = 1'b1;
               next_r.nh = ing_data;
            end
         end
         if (r.hop && rel == HOP_END && r.nh == NH_ICMPV6 &&
            htt_is_mld(ing_data)) begin
            next_r.trap = 1'b1; // see (RULE20)
         end
         if (ing_last) begin
            // a trap found on the final byte still counts
            next_r.ing_trap = next_r.trap;
            // trapped frames go to the host port alone, or to no port while tagging is off
            next_r.ing_fwd_mask = next_r.trap
               ? (r.tag_on ? r.host_mask : 3'h0)
               : ing_lookup_mask; // see (RULE19)
            next_r.pos = '0;
            next_r.tpos = ETYPE_POS;
            next_r.v4 = 1'b0;
            next_r.v6 = 1'b0;
            next_r.snap = 1'b0;
            next_r.hop = 1'b0;
            next_r.trap = 1'b0;
         end
      end

      // host to switch: strip tail, then send payload with new fcs
      strip = !r.tag_on ? TAIL_FCS : (r.ptp_on ? TAIL_TS : TAIL_TAG);
      next_r.rx.valid = 1'b0;
      next_r.rx.last = 1'b0;
      if (lnk.h2d_valid) begin
         next_r.rx = htt_rx_take(r.rx, lnk.h2d_data, DEV_DEPTH); // see (RULE7)
         if (lnk.h2d_last) begin
            tag = next_r.rx.line[TAG_IDX];
            lookup = !r.tag_on || tag[TAG_LOOKUP_BIT]; // see (RULE8)
            next_r.egr_fcs_err = next_r.rx.crc != CRC_RESIDUE;
            next_r.rx.crc = CRC_INIT;
            next_r.rx.fill = 4'h0;
            next_r.rx.cnt = {1'b0, DEV_DEPTH - strip} + {1'b0, TAIL_FCS};
            next_r.egr_lookup = lookup;
            next_r.egr_override = !lookup && tag[TAG_OVERRIDE_BIT];
            next_r.egr_prio = lookup ? PRIO_ZERO
               : tag[TAG_PRIO_LSB +: 2]; // see (RULE10)
            if (lookup) begin
               next_r.egr_mask = egr_lookup_mask & port_tx_enable; // see (RULE21)
            end else begin
               // see (RULE9) (RULE11) (RULE21)
               next_r.egr_mask = tag[2:0] &
                  (tag[TAG_OVERRIDE_BIT] ? ALL_PORTS : port_tx_enable);
            end
            next_r.egr_ts = (r.tag_on && r.ptp_on)
               ? {next_r.rx.line[TS_IDX+3], next_r.rx.line[TS_IDX+2],
                  next_r.rx.line[TS_IDX+1], next_r.rx.line[TS_IDX]}
               : TS_ZERO; // see (RULE15)
         end
      end else if (r.rx.cnt > {1'b0, TAIL_FCS}) begin
         next_r.rx = htt_rx_flush(r.rx, DEV_DEPTH);
         next_r.rx.last = 1'b0;
      end else if (r.rx.cnt != CNT_ZERO) begin
         // fresh fcs over the stripped frame, seed restored after
         next_r.rx.valid = 1'b1;
         next_r.rx.data = ~r.rx.ocrc[7:0]; // see (RULE22)
         next_r.rx.ocrc = {8'hFF, r.rx.ocrc[31:8]};
         next_r.rx.cnt = r.rx.cnt - CNT_ONE;
         next_r.rx.last = r.rx.cnt == CNT_ONE;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         r <= '0; // see (RULE13)
         r.tpos <= ETYPE_POS;
         r.tx.crc <= CRC_INIT;
         r.rx.crc <= CRC_INIT;
         r.rx.ocrc <= CRC_INIT;
      end else begin
         r <= next_r;
      end
   end

   assign lnk.d2h_data = r.tx.data;
   assign lnk.d2h_valid = r.tx.valid;
   assign lnk.d2h_last = r.tx.last;
   assign ing_trap = r.ing_trap;
   assign ing_fwd_mask = r.ing_fwd_mask;
   assign egr_data = r.rx.data;
   assign egr_valid = r.rx.valid;
   assign egr_last = r.rx.last;
   assign egr_mask = r.egr_mask;
   assign egr_prio = r.egr_prio;
   assign egr_lookup = r.egr_lookup;
   assign egr_override = r.egr_override;
   assign egr_ts = r.egr_ts;
   assign egr_fcs_err = r.egr_fcs_err;
endmodule // htt_dev_end
`default_nettype wire

/* File: hdl/htt_host_end.sv */
// host mac end of the host-port trailer logic
`default_nettype none
module htt_host_end
   import htt_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // link to the switch host port
   htt_link_if.host_end lnk,
   // configuration
   input wire logic tag_enable,
   input wire logic ptp_enable,
   // frames to send
   input wire logic [7:0] h_tx_data,
   input wire logic h_tx_valid,
   input wire logic h_tx_last,
   output logic h_tx_ready,
   input wire logic [2:0] h_tx_ports,
   input wire logic [1:0] h_tx_prio,
   input wire logic h_tx_lookup,
   input wire logic h_tx_override,
   input wire logic [31:0] h_tx_ts,
   // frames received
   output logic [7:0] h_rx_data,
   output logic h_rx_valid,
   output logic h_rx_last,
   output logic [1:0] h_rx_port,
   output logic h_rx_ts_flag,
   output logic [31:0] h_rx_ts,
   output logic h_rx_fcs_err
);
   // one spare slot so a payload byte is always left for the last flag
   localparam logic [3:0] HOST_DEPTH = 4'hA;

   typedef struct packed {
      logic tag_on;
      logic ptp_on;
      htt_tx_type tx;
      htt_rx_type rx;
      logic [1:0] port;
      logic ts_flag;
      logic [31:0] ts;
      logic fcs_err;
   } htt_host_state_type;

   htt_host_state_type r;
   htt_host_state_type next_r;

   assign h_tx_ready = r.tx.st == TX_DATA;

   always_comb begin
      logic [7:0] tag;
      logic [3:0] strip;
      tag = {1'b0, h_tx_lookup, h_tx_override, h_tx_prio, h_tx_ports};
      strip = TAIL_FCS;
      next_r = r;
      next_r.tag_on = tag_enable;
      next_r.ptp_on = ptp_enable;
      // timestamp is taken as given: copied delay time or zeros
      next_r.tx = htt_tx_step(r.tx, h_tx_valid && h_tx_ready, h_tx_data,
         h_tx_last,
         (r.tag_on && r.ptp_on) ? {h_tx_ts, tag} : {tag, TS_ZERO}, // see (RULE17) (RULE18)
         !r.tag_on ? NO_TAIL
                   : (r.ptp_on ? TS_TAG_LEN : TAG_LEN)); // see (RULE6)

      next_r.rx.valid = 1'b0;
      next_r.rx.last = 1'b0;
      if (lnk.d2h_valid) begin
         next_r.rx = htt_rx_take(r.rx, lnk.d2h_data, HOST_DEPTH);
         if (lnk.d2h_last) begin
            tag = next_r.rx.line[TAG_IDX];
            if (r.tag_on) begin
               // bit 7 alone tells whether a timestamp precedes
               strip = tag[TAG_FLAG_BIT] ? TAIL_TS : TAIL_TAG; // see (RULE5)
               next_r.port = tag[1:0];
               next_r.ts_flag = tag[TAG_FLAG_BIT];
               next_r.ts = tag[TAG_FLAG_BIT]
                  ? {next_r.rx.line[TS_IDX+3], next_r.rx.line[TS_IDX+2],
                     next_r.rx.line[TS_IDX+1], next_r.rx.line[TS_IDX]}
                  : TS_ZERO;
            end
            next_r.fcs_err = next_r.rx.crc != CRC_RESIDUE;
            next_r.rx.crc = CRC_INIT;
            next_r.rx.fill = 4'h0;
            next_r.rx.cnt = {1'b0, HOST_DEPTH - strip};
         end
      end else if (r.rx.cnt != CNT_ZERO) begin
         next_r.rx = htt_rx_flush(r.rx, HOST_DEPTH);
      end
      // output fcs is not regenerated on this side
      next_r.rx.ocrc = CRC_INIT;
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         r <= '0;
         r.tx.crc <= CRC_INIT;
         r.rx.crc <= CRC_INIT;
         r.rx.ocrc <= CRC_INIT;
      end else begin
         r <= next_r;
      end
   end

   assign lnk.h2d_data = r.tx.data;
   assign lnk.h2d_valid = r.tx.valid;
   assign lnk.h2d_last = r.tx.last;
   assign h_rx_data = r.rx.data;
   assign h_rx_valid = r.rx.valid;
   assign h_rx_last = r.rx.last;
   assign h_rx_port = r.port;
   assign h_rx_ts_flag = r.ts_flag;
   assign h_rx_ts = r.ts;
   assign h_rx_fcs_err = r.fcs_err;
endmodule // htt_host_end
`default_nettype wire

/* File: pkg/htt_link_if.sv */
// interface: byte link between the switch host port and the host mac
`default_nettype none
interface htt_link_if;
   // switch to host
   logic [7:0] d2h_data;
   logic d2h_valid;
   logic d2h_last;
   // host to switch
   logic [7:0] h2d_data;
   logic h2d_valid;
   logic h2d_last;

   modport dev_end (output d2h_data, d2h_valid, d2h_last,
      input h2d_data, h2d_valid, h2d_last);
   modport host_end (input d2h_data, d2h_valid, d2h_last,
      output h2d_data, h2d_valid, h2d_last);
endinterface
`default_nettype wire

/* File: pkg/htt_pkg.sv */
// package: constants, types and helpers of the host-port trailer logic
`default_nettype none
package htt_pkg;
   // trailer byte fields
   localparam int TAG_FLAG_BIT = 7;
   localparam int TAG_LOOKUP_BIT = 6;
   localparam int TAG_OVERRIDE_BIT = 5;
   localparam int TAG_PRIO_LSB = 3;
   localparam int PTP_MODE_BIT = 6;
   localparam logic [2:0] ALL_PORTS = 3'h7;
   localparam logic [2:0] ONE_PORT = 3'h1;
   localparam logic [4:0] RESERVED_ZERO = 5'h00;
   localparam logic [1:0] PRIO_ZERO = 2'h0;
   localparam logic [31:0] TS_ZERO = 32'h00000000;
   // tail lengths in bytes: fcs, tag+fcs, timestamp+tag+fcs
   localparam logic [3:0] TAIL_FCS = 4'h4;
   localparam logic [3:0] TAIL_TAG = 4'h5;
   localparam logic [3:0] TAIL_TS = 4'h9;
   localparam logic [3:0] NO_TAIL = 4'h0;
   localparam logic [3:0] TAG_LEN = 4'h1;
   localparam logic [3:0] TS_TAG_LEN = 4'h5;
   // positions in the hold line, index 0 is the newest byte
   localparam int LINE_MAX = 10;
   localparam int TAG_IDX = 4;
   localparam int TS_IDX = 5;
   localparam logic [4:0] LINK_GAP = 5'h10;
   localparam logic [4:0] CNT_ONE = 5'h01;
   localparam logic [4:0] CNT_ZERO = 5'h00;
   // frame check sequence, reflected form
   localparam logic [31:0] CRC_POLY = 32'hEDB88320;
   localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
   localparam logic [31:0] CRC_RESIDUE = 32'hDEBB20E3;
   // frame classifier
   localparam int POS_W = 14;
   localparam logic [13:0] POS_ONE = 14'h0001;
   localparam logic [13:0] ETYPE_POS = 14'h000D;
   localparam logic [13:0] VLAN_LEN = 14'h0004;
   localparam logic [13:0] SNAP_LEN = 14'h0008;
   localparam logic [13:0] V4_VER_OFF = 14'h0000;
   localparam logic [13:0] V4_PROTO_OFF = 14'h0009;
   localparam logic [13:0] V6_NH_OFF = 14'h0006;
   localparam logic [13:0] V6_HDR_LEN = 14'h0028;
   localparam logic [13:0] HOP_END = 14'h0030;
   localparam logic [15:0] ET_VLAN = 16'h8100;
   localparam logic [15:0] ET_IPV4 = 16'h0800;
   localparam logic [15:0] ET_IPV6 = 16'h86DD;
   localparam logic [15:0] ET_MAX_LEN = 16'h0600;
   localparam logic [3:0] IPV4_VER = 4'h4;
   localparam logic [7:0] IGMP_PROTO = 8'h02;
   localparam logic [7:0] NH_HOP = 8'h00;
   localparam logic [7:0] NH_ICMPV6 = 8'h3A;
   localparam logic [7:0] MLD_QUERY = 8'h82;
   localparam logic [7:0] MLD_REPORT = 8'h83;
   localparam logic [7:0] MLD_DONE = 8'h84;
   localparam logic [7:0] MLD_REPORT2 = 8'h8F;

   typedef enum logic [1:0] {TX_DATA, TX_TAIL, TX_FCS, TX_GAP}
      htt_tx_state_type;

   typedef struct packed {
      htt_tx_state_type st;
      logic [4:0] cnt;
      logic [31:0] crc;
      logic [39:0] tail;
      logic [7:0] data;
      logic valid;
      logic last;
   } htt_tx_type;

   typedef struct packed {
      logic [LINE_MAX-1:0][7:0] line;
      logic [3:0] fill;
      logic [4:0] cnt;
      logic [31:0] crc;
      logic [31:0] ocrc;
      logic [7:0] data;
      logic valid;
      logic last;
   } htt_rx_type;

   function automatic logic [31:0] htt_crc_next(input logic [31:0] c,
      input logic [7:0] d);
      logic [31:0] r;
      r = c ^ {24'h000000, d};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   function automatic logic htt_is_mld(input logic [7:0] t);
      return t == MLD_QUERY || t == MLD_REPORT || t == MLD_DONE ||
         t == MLD_REPORT2;
   endfunction

   function automatic logic [31:0] htt_ts_pack(input logic [1:0] sec,
      input logic [29:0] ns);
      return {sec, ns}; // see (RULE16)
   endfunction

   // sender: payload, then tail bytes msb first, then fcs, then a gap
   function automatic htt_tx_type htt_tx_step(input htt_tx_type s,
      input logic take, input logic [7:0] d, input logic last,
      input logic [39:0] tail, input logic [3:0] tail_len);
      htt_tx_type n;
      n = s;
      n.valid = 1'b0;
      n.last = 1'b0;
      case (s.st)
         TX_DATA: begin
            if (take) begin
               n.valid = 1'b1;
               n.data = d;
               n.crc = htt_crc_next(s.crc, d);
               if (last) begin
                  n.tail = tail;
                  n.cnt = {1'b0, tail_len};
                  n.st = (tail_len == NO_TAIL) ? TX_FCS : TX_TAIL;
                  if (tail_len == NO_TAIL) begin
                     n.cnt = {1'b0, TAIL_FCS};
                  end
               end
            end
         end
         TX_TAIL: begin
            n.valid = 1'b1;
            n.data = s.tail[39:32];
            n.tail = {s.tail[31:0], 8'h00};
            n.crc = htt_crc_next(s.crc, s.tail[39:32]);
            n.cnt = s.cnt - CNT_ONE;
            if (s.cnt == CNT_ONE) begin
               n.st = TX_FCS;
               n.cnt = {1'b0, TAIL_FCS};
            end
         end
         TX_FCS: begin
            // fcs goes out low byte first; ones shift in so the
            // register is back at its seed after the fourth byte
            n.valid = 1'b1;
            n.data = ~s.crc[7:0]; // see (RULE1) (RULE22)
            n.crc = {8'hFF, s.crc[31:8]};
            n.cnt = s.cnt - CNT_ONE;
            if (s.cnt == CNT_ONE) begin
               n.last = 1'b1;
               n.st = TX_GAP;
               n.cnt = LINK_GAP;
            end
         end
         TX_GAP: begin
            n.cnt = s.cnt - CNT_ONE;
            if (s.cnt == CNT_ONE) begin
               n.st = TX_DATA;
            end
         end
         default: begin
            n.st = TX_DATA;
         end
      endcase
      return n;
   endfunction

   // receiver: hold the newest bytes, release the oldest when full
   function automatic htt_rx_type htt_rx_take(input htt_rx_type s,
      input logic [7:0] d, input logic [3:0] depth);
      htt_rx_type n;
      n = s;
      n.last = 1'b0;
      n.valid = s.fill == depth;
      n.data = s.line[depth - 4'h1];
      if (n.valid) begin
         n.ocrc = htt_crc_next(s.ocrc, n.data);
      end else begin
         n.fill = s.fill + 4'h1;
      end
      n.line = {s.line[LINE_MAX-2:0], d};
      n.crc = htt_crc_next(s.crc, d);
      return n;
   endfunction

   function automatic htt_rx_type htt_rx_flush(input htt_rx_type s,
      input logic [3:0] depth);
      htt_rx_type n;
      n = s;
      n.valid = 1'b1;
      n.data = s.line[depth - 4'h1];
      n.ocrc = htt_crc_next(s.ocrc, n.data);
      n.line = {s.line[LINE_MAX-2:0], 8'h00};
      n.cnt = s.cnt - CNT_ONE;
      n.last = s.cnt == CNT_ONE;
      return n;
   endfunction
endpackage
`default_nettype wire

/* File: tb/htt_chk.sv */
// checker: framing and trailer fields on the byte link
`default_nettype none
module htt_chk (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // switch end configuration
   input wire logic [2:0] trailer_enable,
   input wire logic [7:0] precision_time_cfg1,
   // link signals
   input wire logic [7:0] d2h_data,
   input wire logic d2h_valid,
   input wire logic d2h_last,
   input wire logic [7:0] h2d_data,
   input wire logic h2d_valid,
   input wire logic h2d_last
);
   timeunit 1ns;
   timeprecision 1ns;
   // host port is port 1 in this bench
   wire logic tag_on = trailer_enable == 3'h1;
   wire logic ptp_on = precision_time_cfg1[6];
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   property p_d2h_end; d2h_last |-> d2h_valid; endproperty
   property p_d2h_cont; d2h_valid && !d2h_last |=> d2h_valid; endproperty
   property p_h2d_cont; h2d_valid && !h2d_last |=> h2d_valid; endproperty
   property p_d2h_gap; d2h_last |=> !d2h_valid [*8]; endproperty
   property p_h2d_gap; h2d_last |=> !h2d_valid [*8]; endproperty
   property p_d2h_rsvd;
      d2h_last && tag_on |->
         ($past(d2h_data, 4) & 8'h7C) == 8'h00 &&
         ($past(d2h_data, 4) & 8'h03) != 8'h03;
   endproperty
   property p_d2h_flag;
      d2h_last && tag_on && !ptp_on |-> ($past(d2h_data, 4) & 8'h80) == 8'h00;
   endproperty
   property p_h2d_rsvd;
      h2d_last && tag_on |-> ($past(h2d_data, 4) & 8'h80) == 8'h00;
   endproperty
   a_d2h_end: assert property (p_d2h_end)
      else $error("switch last without valid");
   a_d2h_cont: assert property (p_d2h_cont)
      else $error("switch frame has a hole");
   a_h2d_cont: assert property (p_h2d_cont)
      else $error("host frame has a hole");
   a_d2h_gap: assert property (p_d2h_gap)
      else $error("switch frame gap too short");
   a_h2d_gap: assert property (p_h2d_gap)
      else $error("host frame gap too short");
   a_d2h_rsvd: assert property (p_d2h_rsvd)
      else $error("switch trailer reserved bits set");
   a_d2h_flag: assert property (p_d2h_flag)
      else $error("timestamp flag set with timestamps off");
   a_h2d_rsvd: assert property (p_h2d_rsvd)
      else $error("host trailer bit 7 set");
   c_ptp: cover property (d2h_last && ptp_on);
   c_h2d: cover property (h2d_last && tag_on);
   c_untagged: cover property (d2h_last && !tag_on);
endmodule // htt_chk
`default_nettype wire

/* File: tb/tb.sv */
// testbench: switch end and host end joined over the byte link
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk, ing_ready, ing_trap, egr_valid, egr_last, egr_lookup;
   logic egr_override, egr_fcs_err, h_tx_ready, h_rx_valid, h_rx_last;
   logic h_rx_ts_flag, h_rx_fcs_err;
   logic rst_n = 1'b0, tag_enable = 1'b1, ptp_enable = 1'b0;
   logic ing_valid = 1'b0, ing_last = 1'b0, ing_ptp = 1'b0;
   logic h_tx_valid = 1'b0, h_tx_last = 1'b0;
   logic h_tx_lookup = 1'b0, h_tx_override = 1'b0;
   logic [1:0] link_port = 2'h0, ing_port = 2'h0, ing_ts_sec = 2'h3;
   logic [1:0] h_tx_prio = 2'h0, egr_prio, h_rx_port;
   logic [2:0] trailer_enable = 3'h1, port_tx_enable = 3'h3;
   logic [2:0] ing_lookup_mask = 3'h6, egr_lookup_mask = 3'h5;
   logic [2:0] h_tx_ports = 3'h6, ing_fwd_mask, egr_mask;
   logic [7:0] precision_time_cfg1 = 8'h00, ing_data = 8'h00;
   logic [7:0] h_tx_data = 8'h00, egr_data, h_rx_data;
   logic [29:0] ing_ts_ns = 30'h01234567;
   logic [31:0] h_tx_ts = 32'hC1234567, egr_ts, h_rx_ts;
   logic [7:0] rxq[$], eq[$];
   int error_cnt = 0, checks_done = 0, lb = 0, lc = 0;

   htt_link_if lnk();
   htt_dev_end u_htt_dev_end(.core_clk, .rst_n, .lnk(lnk), .trailer_enable,
      .link_port, .precision_time_cfg1, .port_tx_enable, .ing_data,
      .ing_valid, .ing_last, .ing_ready, .ing_port, .ing_ptp, .ing_ts_sec,
      .ing_ts_ns, .ing_lookup_mask, .ing_trap, .ing_fwd_mask,
      .egr_lookup_mask, .egr_data, .egr_valid, .egr_last, .egr_mask,
      .egr_prio, .egr_lookup, .egr_override, .egr_ts, .egr_fcs_err);
   htt_host_end u_htt_host_end(.core_clk, .rst_n, .lnk(lnk), .tag_enable,
      .ptp_enable, .h_tx_data, .h_tx_valid, .h_tx_last, .h_tx_ready,
      .h_tx_ports, .h_tx_prio, .h_tx_lookup, .h_tx_override, .h_tx_ts,
      .h_rx_data, .h_rx_valid, .h_rx_last, .h_rx_port, .h_rx_ts_flag,
      .h_rx_ts, .h_rx_fcs_err);
   htt_chk u_htt_chk(.core_clk, .rst_n, .trailer_enable, .precision_time_cfg1,
      .d2h_data(lnk.d2h_data), .d2h_valid(lnk.d2h_valid),
      .d2h_last(lnk.d2h_last), .h2d_data(lnk.h2d_data),
      .h2d_valid(lnk.h2d_valid), .h2d_last(lnk.h2d_last));

   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   always @(posedge core_clk) begin
      if (h_rx_valid) rxq.push_back(h_rx_data);
      if (egr_valid) eq.push_back(egr_data);
      if (lnk.d2h_valid) lb++;
      if (h_rx_last) lc = rxq.size();
      if (egr_last) lc = eq.size();
   end

   task automatic chk(input string s, input logic [31:0] e, g);
      checks_done++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR %s expected %0h seen %0h", s, e, g);
      end
   endtask

   function automatic logic [31:0] res(input logic [7:0] q[$]);
      logic [31:0] c = 32'hFFFFFFFF;
      foreach (q[i])
         for (int b = 0; b < 8; b++)
            c = (c >> 1) ^ ((c[0] ^ q[i][b]) ? 32'hEDB88320 : 32'h0);
      return c;
   endfunction

   // byte i of a test frame; g gives an ipv4 igmp header
   function automatic logic [7:0] fb(input int i, input logic g);
      if (g && i == 12) return 8'h08;
      if (g && i == 13) return 8'h00;
      if (g && i == 14) return 8'h45;
      if (g && i == 23) return 8'h02;
      return 8'(i) + 8'h30;
   endfunction

   // s selects the host sender, else the switch ingress side
   task automatic snd(input logic s, input int n, input logic g);
      int k;
      rxq.delete();
      eq.delete();
      lb = 0;
      lc = 0;
      for (int i = 0; i < n; i++) begin
         @(negedge core_clk);
         ing_data = fb(i, g);
         h_tx_data = fb(i, g);
         ing_valid = !s;
         h_tx_valid = s;
         ing_last = !s && i == n - 1;
         h_tx_last = s && i == n - 1;
         while ((s ? h_tx_ready : ing_ready) !== 1'b1) @(negedge core_clk);
      end
      @(negedge core_clk);
      ing_valid = 1'b0;
      h_tx_valid = 1'b0;
      ing_last = 1'b0;
      h_tx_last = 1'b0;
      k = s ? n + 4 : n;
      for (int j = 0; j < 400 && (s ? eq.size() : rxq.size()) < k; j++)
         @(posedge core_clk);
      @(negedge core_clk);
      chk("count", k, s ? eq.size() : rxq.size());
      chk("last", k, lc);
      if (s) chk("ofcs", 32'hDEBB20E3, res(eq));
      for (int i = 0; i < n; i++)
         chk("byte", fb(i, g), s ? eq[i] : rxq[i]);
      chk("fcs", 0, s ? egr_fcs_err : h_rx_fcs_err);
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge core_clk);
      error_cnt++;
      print_verdict();
   end

   initial begin
      repeat (4) @(negedge core_clk);
      rst_n = 1'b1;
      repeat (2) @(negedge core_clk);
      for (int p = 0; p < 3; p++) begin
         ing_port = 2'(p);
         snd(0, 12, 0);
         chk("port", p, h_rx_port);
         chk("flag", 0, h_rx_ts_flag);
         chk("link", 17, lb);
         chk("fwd", 3'h6, ing_fwd_mask);
      end
      $display("test ingress ports done");
      precision_time_cfg1 = 8'h40;
      ptp_enable = 1'b1;
      for (int t = 0; t < 2; t++) begin
         ing_ptp = t[0];
         snd(0, 12, 0);
         chk("flag", t, h_rx_ts_flag);
         chk("link", 17 + 4 * t, lb);
      end
      chk("stamp", 32'hC1234567, h_rx_ts);
      $display("test timestamp done");
      for (int c = 0; c < 3; c++) begin
         h_tx_lookup = c == 2;
         h_tx_override = c == 1;
         h_tx_prio = 2'(c + 1);
         snd(1, 12, 0);
         chk("mask", c == 0 ? 2 : c == 1 ? 6 : 1, egr_mask);
         chk("prio", c == 2 ? 0 : c + 1, egr_prio);
         chk("lookup", c == 2, egr_lookup);
         chk("override", c == 1, egr_override);
         chk("stamp", 32'hC1234567, egr_ts);
      end
      $display("test host trailer done");
      snd(0, 30, 1);
      chk("trap", 1, ing_trap);
      chk("fwd", 3'h1, ing_fwd_mask);
      trailer_enable = 3'h3;
      tag_enable = 1'b0;
      snd(0, 12, 0);
      chk("link", 16, lb);
      $display("test trap and untagged done");
      print_verdict();
   end
endmodule // tb
`default_nettype wire
